// ==== rosr_pkg.sv ====
// Constants for the rear output signal router.
// Assumes one 20 MHz clock shared with every signal source feeding it.
//
// Behaviour
// - Each connector has its own source selection
// - Any selection accepted in any mode
// - Feature signals idle until feature active
// - Code 0 drives nothing on connector
// - Code 4 routes 3.84 MHz chip clock
// - Codes 5,6,10: frame reset, sync, slot
// - Codes 11,13: 10 ms, 80 ms pulses
// - Code 20: data clock through gaps
// - Code 30: data clock gapped in gaps
// - Code 30 equals 20 without compressed mode
// - Codes 21-23: TPC, TFCI, pilot clocks
// - Code 24: channel bits before spreading
// - Codes 25,26,28: slot, frame, bit clock
// - Code 33: compressed mode gap indicator
// - Codes 35-37: paging data, slot, frame
// - Codes 38,39: common channel clock, data
// - Codes 40,41: playback frame, TPC bits
// - Code 42: multi unit sync trigger out
`default_nettype none
package rosr_pkg;
    // ==========================================================
    // Bus widths and register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SEL_W = 6;
    localparam logic [ADDR_W-1:0] SEL_BASE_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h9;
    localparam int CTRL_CM_EN_BIT = 0;
    localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
    localparam logic CM_EN_RESET = 1'b0;
    // ==========================================================
    // Selection codes
    localparam logic [SEL_W-1:0] SRC_NONE = 6'h00;
    localparam logic [SEL_W-1:0] SRC_CHIP_CLK = 6'h04;
    localparam logic [SEL_W-1:0] SRC_SFN_RESET = 6'h05;
    localparam logic [SEL_W-1:0] SRC_SFN_SYNC = 6'h06;
    localparam logic [SEL_W-1:0] SRC_SCH_SLOT = 6'h0A;
    localparam logic [SEL_W-1:0] SRC_FRAME_10MS = 6'h0B;
    localparam logic [SEL_W-1:0] SRC_FRAME_80MS = 6'h0D;
    localparam logic [SEL_W-1:0] SRC_DATA_CLK_CONT = 6'h14;
    localparam logic [SEL_W-1:0] SRC_TPC_CLK = 6'h15;
    localparam logic [SEL_W-1:0] SRC_TFCI_CLK = 6'h16;
    localparam logic [SEL_W-1:0] SRC_PILOT_CLK = 6'h17;
    localparam logic [SEL_W-1:0] SRC_DPCH_STREAM = 6'h18;
    localparam logic [SEL_W-1:0] SRC_DPCH_SLOT = 6'h19;
    localparam logic [SEL_W-1:0] SRC_DPCH_FRAME = 6'h1A;
    localparam logic [SEL_W-1:0] SRC_DPCH_CLK = 6'h1C;
    localparam logic [SEL_W-1:0] SRC_DATA_CLK_GAPPED = 6'h1E;
    localparam logic [SEL_W-1:0] SRC_CM_FRAME_IND = 6'h20;
    localparam logic [SEL_W-1:0] SRC_CM_GAP_IND = 6'h21;
    localparam logic [SEL_W-1:0] SRC_PICH_DATA = 6'h23;
    localparam logic [SEL_W-1:0] SRC_PICH_SLOT = 6'h24;
    localparam logic [SEL_W-1:0] SRC_PICH_FRAME = 6'h25;
    localparam logic [SEL_W-1:0] SRC_PCCPCH_CLK = 6'h26;
    localparam logic [SEL_W-1:0] SRC_PCCPCH_DATA = 6'h27;
    localparam logic [SEL_W-1:0] SRC_PLAYBACK_FRAME = 6'h28;
    localparam logic [SEL_W-1:0] SRC_TPC_BITS = 6'h29;
    localparam logic [SEL_W-1:0] SRC_SYNC_TRIG = 6'h2A;
endpackage
`default_nettype wire

// ==== rosr_router.sv ====
// Rear output signal router: per-connector source selection.
// Assumes all sources are generated on clk_in; none are resynchronised.
`timescale 1ns/10ps
`default_nettype none
module rosr_router #(
    parameter int NUM_OUT = 7
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [rosr_pkg::ADDR_W-1:0] addr_in,
    input wire logic [rosr_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [rosr_pkg::DATA_W-1:0] rdata_out,
    input wire logic chip_clk_in,
    input wire logic sfn_reset_in,
    input wire logic sfn_sync_in,
    input wire logic sch_slot_in,
    input wire logic frame_10ms_in,
    input wire logic frame_80ms_in,
    input wire logic dpdch_clk_in,
    input wire logic tpc_clk_in,
    input wire logic tfci_clk_in,
    input wire logic pilot_clk_in,
    input wire logic dpch_stream_in,
    input wire logic dpch_slot_in,
    input wire logic dpch_frame_in,
    input wire logic dpch_clk_in,
    input wire logic cm_frame_ind_in,
    input wire logic cm_gap_in,
    input wire logic pich_data_in,
    input wire logic pich_slot_in,
    input wire logic pich_frame_in,
    input wire logic pccpch_clk_in,
    input wire logic pccpch_data_in,
    input wire logic chip_waveform_playback_frame_in,
    input wire logic tpc_bits_in,
    input wire logic multi_unit_sync_trigger_in,
    output logic [NUM_OUT-1:0] conn_out,
    output logic [NUM_OUT-1:0] conn_oe_out
);
    import rosr_pkg::*;

    // ==========================================================
    // Parameter check
    // Status register shows one bit per connector, map holds eight
    if (NUM_OUT < 1 || NUM_OUT > 8) begin : g_bad_num_out
        $error("NUM_OUT must be 1 to 8");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [NUM_OUT-1:0][SEL_W-1:0] sel;
        logic cm_en;
        logic [NUM_OUT-1:0] conn;
        logic [NUM_OUT-1:0] oe;
        logic [DATA_W-1:0] rdata;
    } rosr_state_t;

    rosr_state_t st_q;
    rosr_state_t st_d;
    logic [63:0] src;
    logic cm_active;

    // ==========================================================
    // Source table, indexed by selection code
    always_comb begin
        src = 64'h0;
        cm_active = st_q.cm_en;
        src[SRC_CHIP_CLK] = chip_clk_in;
        src[SRC_SFN_RESET] = sfn_reset_in;
        src[SRC_SFN_SYNC] = sfn_sync_in;
        src[SRC_SCH_SLOT] = sch_slot_in;
        src[SRC_FRAME_10MS] = frame_10ms_in;
        src[SRC_FRAME_80MS] = frame_80ms_in;
        src[SRC_DATA_CLK_CONT] = dpdch_clk_in;
        src[SRC_TPC_CLK] = tpc_clk_in;
        src[SRC_TFCI_CLK] = tfci_clk_in;
        src[SRC_PILOT_CLK] = pilot_clk_in;
        src[SRC_DPCH_STREAM] = dpch_stream_in;
        src[SRC_DPCH_SLOT] = dpch_slot_in;
        src[SRC_DPCH_FRAME] = dpch_frame_in;
        src[SRC_DPCH_CLK] = dpch_clk_in;
        // Gap only masks while compressed mode runs, else same as code 20
        src[SRC_DATA_CLK_GAPPED] = dpdch_clk_in & ~(cm_active & cm_gap_in);
        // Feature signals held idle until compressed mode is on
        src[SRC_CM_FRAME_IND] = cm_frame_ind_in & cm_active;
        src[SRC_CM_GAP_IND] = cm_gap_in & cm_active;
        src[SRC_PICH_DATA] = pich_data_in;
        src[SRC_PICH_SLOT] = pich_slot_in;
        src[SRC_PICH_FRAME] = pich_frame_in;
        src[SRC_PCCPCH_CLK] = pccpch_clk_in;
        src[SRC_PCCPCH_DATA] = pccpch_data_in;
        src[SRC_PLAYBACK_FRAME] = chip_waveform_playback_frame_in;
        src[SRC_TPC_BITS] = tpc_bits_in;
        // Passed straight through; aligning on it is the receivers' job
        src[SRC_SYNC_TRIG] = multi_unit_sync_trigger_in;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;
        for (int i = 0; i < NUM_OUT; i++) begin
            // Any code is stored whatever mode is active
            if (wr_in && addr_in == SEL_BASE_OFS + ADDR_W'(i)) begin
                st_d.sel[i] = wdata_in[SEL_W-1:0];
            end
            // Code 0 gives a low, undriven pin; unused codes drive the pin low
            st_d.conn[i] = src[st_q.sel[i]];
            st_d.oe[i] = (st_q.sel[i] != SRC_NONE);
        end
        if (wr_in && addr_in == CTRL_OFS) begin
            st_d.cm_en = wdata_in[CTRL_CM_EN_BIT];
        end
        if (rd_in) begin
            if (addr_in < SEL_BASE_OFS + ADDR_W'(NUM_OUT)) begin
                st_d.rdata = DATA_W'(st_q.sel[addr_in[2:0]]);
            end else if (addr_in == CTRL_OFS) begin
                st_d.rdata = DATA_W'(st_q.cm_en);
            end else if (addr_in == STATUS_OFS) begin
                st_d.rdata = DATA_W'(st_q.conn);
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= '0;
            for (int i = 0; i < NUM_OUT; i++) begin
                st_q.sel[i] <= SEL_RESET;
            end
            st_q.cm_en <= CM_EN_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign conn_out = st_q.conn;
    assign conn_oe_out = st_q.oe;
    assign rdata_out = st_q.rdata;

    // ==========================================================
    // Checks, on connector 0 as representative
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_sel_keeps_other: assert property (
        wr_in && addr_in != SEL_BASE_OFS |=> $stable(st_q.sel[0]))
        else $error("connector 0 selection changed by other write");
    a_sel_any_code: assert property (
        wr_in && addr_in == SEL_BASE_OFS |=> st_q.sel[0] == $past(wdata_in[SEL_W-1:0]))
        else $error("selection write not taken");
    a_cm_ind_idle: assert property (
        st_q.sel[0] == SRC_CM_FRAME_IND && !st_q.cm_en |=> !conn_out[0])
        else $error("compressed indicator active while feature off");
    a_none_undriven: assert property (
        st_q.sel[0] == SRC_NONE |=> !conn_oe_out[0] && !conn_out[0])
        else $error("code 0 connector driven");
    a_chip_clk_route: assert property (
        st_q.sel[0] == SRC_CHIP_CLK |=> conn_out[0] == $past(chip_clk_in) && conn_oe_out[0])
        else $error("chip clock not routed");
    a_sfn_sync_route: assert property (
        st_q.sel[0] == SRC_SFN_SYNC |=> conn_out[0] == $past(sfn_sync_in))
        else $error("frame sync not routed");
    a_frame80_route: assert property (
        st_q.sel[0] == SRC_FRAME_80MS |=> conn_out[0] == $past(frame_80ms_in))
        else $error("80 ms pulse not routed");
    a_clk_through_gap: assert property (
        st_q.sel[0] == SRC_DATA_CLK_CONT && cm_gap_in && dpdch_clk_in |=> conn_out[0])
        else $error("continuous data clock dropped in gap");
    a_clk_gap_masked: assert property (
        st_q.sel[0] == SRC_DATA_CLK_GAPPED && st_q.cm_en && cm_gap_in |=> !conn_out[0])
        else $error("gapped data clock pulsed in gap");
    a_gapped_equal_cont: assert property (
        st_q.sel[0] == SRC_DATA_CLK_GAPPED && !st_q.cm_en |=> conn_out[0] == $past(dpdch_clk_in))
        else $error("code 30 differs from code 20 without compressed mode");
    a_pich_route: assert property (
        st_q.sel[0] == SRC_PICH_DATA |=> conn_out[0] == $past(pich_data_in))
        else $error("paging data not routed");
    a_sync_trig_route: assert property (
        st_q.sel[0] == SRC_SYNC_TRIG |=> conn_out[0] == $past(multi_unit_sync_trigger_in))
        else $error("sync trigger not routed");
    a_reset_clears: assert property (@(posedge clk_in) disable iff (1'b0)
        reset_in |=> st_q.sel[0] == SRC_NONE && !conn_oe_out[0])
        else $error("reset left a selection");

    // ==========================================================
    // Register port checks
    a_cm_en_write: assert property (
        wr_in && addr_in == CTRL_OFS
        |=> st_q.cm_en == $past(wdata_in[CTRL_CM_EN_BIT]))
        else $error("compressed mode enable not taken");

    a_sel_readback: assert property (
        rd_in && addr_in == SEL_BASE_OFS
        |=> rdata_out == DATA_W'($past(st_q.sel[0])))
        else $error("selection read back wrong");

    a_ctrl_read: assert property (
        rd_in && addr_in == CTRL_OFS
        |=> rdata_out == DATA_W'($past(st_q.cm_en)))
        else $error("control read back wrong");

    a_status_read: assert property (
        rd_in && addr_in == STATUS_OFS
        |=> rdata_out == DATA_W'($past(conn_out)))
        else $error("status does not show connectors");

    a_rdata_idle: assert property (
        !rd_in
        |=> rdata_out == '0)
        else $error("read data left standing");

    a_unmapped_read: assert property (
        rd_in && addr_in > STATUS_OFS
        |=> rdata_out == '0)
        else $error("unmapped read not zero");

    // ==========================================================
    // Selection, reset and routing checks, repeated on every connector
    for (genvar gi = 0; gi < NUM_OUT; gi++) begin : g_conn_chk
        a_sel_isolated: assert property (
            wr_in && addr_in != SEL_BASE_OFS + ADDR_W'(gi)
            |=> $stable(st_q.sel[gi]))
            else $error("selection changed by another write");

        a_sel_written: assert property (
            wr_in && addr_in == SEL_BASE_OFS + ADDR_W'(gi)
            |=> st_q.sel[gi] == $past(wdata_in[SEL_W-1:0]))
            else $error("selection write lost");

        a_none_released: assert property (
            st_q.sel[gi] == SRC_NONE
            |=> !conn_oe_out[gi] && !conn_out[gi])
            else $error("released connector driven");

        a_code_driven: assert property (
            st_q.sel[gi] != SRC_NONE
            |=> conn_oe_out[gi])
            else $error("selected connector not driven");

        a_reset_each: assert property (@(posedge clk_in) disable iff (1'b0)
            reset_in
            |=> st_q.sel[gi] == SRC_NONE && !conn_out[gi])
            else $error("reset left a connector active");

        a_chip_clk_each: assert property (
            st_q.sel[gi] == SRC_CHIP_CLK
            |=> conn_out[gi] == $past(chip_clk_in))
            else $error("chip clock not routed");

        a_sfn_reset_route: assert property (
            st_q.sel[gi] == SRC_SFN_RESET
            |=> conn_out[gi] == $past(sfn_reset_in))
            else $error("frame number reset not routed");

        a_sfn_sync_each: assert property (
            st_q.sel[gi] == SRC_SFN_SYNC
            |=> conn_out[gi] == $past(sfn_sync_in))
            else $error("frame sync not routed");

        a_sch_slot_route: assert property (
            st_q.sel[gi] == SRC_SCH_SLOT
            |=> conn_out[gi] == $past(sch_slot_in))
            else $error("slot pulse not routed");

        a_frame10_route: assert property (
            st_q.sel[gi] == SRC_FRAME_10MS
            |=> conn_out[gi] == $past(frame_10ms_in))
            else $error("10 ms pulse not routed");

        a_cont_clk_route: assert property (
            st_q.sel[gi] == SRC_DATA_CLK_CONT
            |=> conn_out[gi] == $past(dpdch_clk_in))
            else $error("continuous data clock not routed");

        a_gapped_open: assert property (
            st_q.sel[gi] == SRC_DATA_CLK_GAPPED && !cm_gap_in
            |=> conn_out[gi] == $past(dpdch_clk_in))
            else $error("gapped data clock lost outside gap");

        a_tpc_clk_route: assert property (
            st_q.sel[gi] == SRC_TPC_CLK
            |=> conn_out[gi] == $past(tpc_clk_in))
            else $error("power control clock not routed");

        a_tfci_clk_route: assert property (
            st_q.sel[gi] == SRC_TFCI_CLK
            |=> conn_out[gi] == $past(tfci_clk_in))
            else $error("format indicator clock not routed");

        a_pilot_clk_route: assert property (
            st_q.sel[gi] == SRC_PILOT_CLK
            |=> conn_out[gi] == $past(pilot_clk_in))
            else $error("pilot clock not routed");

        a_stream_route: assert property (
            st_q.sel[gi] == SRC_DPCH_STREAM
            |=> conn_out[gi] == $past(dpch_stream_in))
            else $error("channel bit stream not routed");

        a_dpch_slot_route: assert property (
            st_q.sel[gi] == SRC_DPCH_SLOT
            |=> conn_out[gi] == $past(dpch_slot_in))
            else $error("channel slot pulse not routed");

        a_dpch_frame_route: assert property (
            st_q.sel[gi] == SRC_DPCH_FRAME
            |=> conn_out[gi] == $past(dpch_frame_in))
            else $error("channel frame pulse not routed");

        a_dpch_clk_route: assert property (
            st_q.sel[gi] == SRC_DPCH_CLK
            |=> conn_out[gi] == $past(dpch_clk_in))
            else $error("channel bit clock not routed");

        a_cm_ind_route: assert property (
            st_q.sel[gi] == SRC_CM_FRAME_IND && st_q.cm_en
            |=> conn_out[gi] == $past(cm_frame_ind_in))
            else $error("compressed frame indicator not routed");

        a_gap_ind_route: assert property (
            st_q.sel[gi] == SRC_CM_GAP_IND && st_q.cm_en
            |=> conn_out[gi] == $past(cm_gap_in))
            else $error("gap indicator not routed");

        a_gap_ind_idle: assert property (
            st_q.sel[gi] == SRC_CM_GAP_IND && !st_q.cm_en
            |=> !conn_out[gi])
            else $error("gap indicator active while feature off");

        a_pich_slot_route: assert property (
            st_q.sel[gi] == SRC_PICH_SLOT
            |=> conn_out[gi] == $past(pich_slot_in))
            else $error("paging slot pulse not routed");

        a_pich_frame_route: assert property (
            st_q.sel[gi] == SRC_PICH_FRAME
            |=> conn_out[gi] == $past(pich_frame_in))
            else $error("paging frame pulse not routed");

        a_pccpch_clk_route: assert property (
            st_q.sel[gi] == SRC_PCCPCH_CLK
            |=> conn_out[gi] == $past(pccpch_clk_in))
            else $error("common channel clock not routed");

        a_pccpch_data_route: assert property (
            st_q.sel[gi] == SRC_PCCPCH_DATA
            |=> conn_out[gi] == $past(pccpch_data_in))
            else $error("common channel data not routed");

        a_playback_route: assert property (
            st_q.sel[gi] == SRC_PLAYBACK_FRAME
            |=> conn_out[gi] == $past(chip_waveform_playback_frame_in))
            else $error("playback frame pulse not routed");

        a_tpc_bits_route: assert property (
            st_q.sel[gi] == SRC_TPC_BITS
            |=> conn_out[gi] == $past(tpc_bits_in))
            else $error("power control bits not routed");

        a_trig_each: assert property (
            st_q.sel[gi] == SRC_SYNC_TRIG
            |=> conn_out[gi] == $past(multi_unit_sync_trigger_in))
            else $error("sync trigger not routed");
    end

    c_chip_clk: cover property (st_q.sel[0] == SRC_CHIP_CLK ##1 conn_out[0]);
    c_gap_mask: cover property (st_q.sel[0] == SRC_DATA_CLK_GAPPED && st_q.cm_en && cm_gap_in);
    c_deselect: cover property (st_q.sel[0] != SRC_NONE ##1 st_q.sel[0] == SRC_NONE);
    c_sync_trig: cover property (st_q.sel[0] == SRC_SYNC_TRIG ##1 conn_out[0]);
    c_gap_ind: cover property (st_q.sel[0] == SRC_CM_GAP_IND && st_q.cm_en);
endmodule
`default_nettype wire

// ==== rosr_pkg_end_marker_unused.sv ====
// Intentionally empty: no content.

// ==== rosr_far_end.sv ====
// Far-end model: test gear watching the rear connectors.
// Assumes connector levels change only just after clk_in edges.
`timescale 1ns/10ps
`default_nettype none
module rosr_far_end #(
    parameter int NUM_OUT = 7
) (
    input wire logic clk_in,
    input wire logic [NUM_OUT-1:0] conn_in,
    input wire logic [NUM_OUT-1:0] oe_in,
    output logic [NUM_OUT-1:0] line_out,
    output var int trig_count_out
);
    logic [NUM_OUT-1:0] prev_q = '0;
    int count_q = 0;
    // ==========================================================
    // Line level
    // Released pin toggles, so a stale level never looks valid
    assign line_out = (conn_in & oe_in) | (~prev_q & ~oe_in);
    assign trig_count_out = count_q;
    // ==========================================================
    // Trigger receiver on connector 0
    always @(posedge clk_in) begin
        prev_q <= line_out;
        if (oe_in[0] && line_out[0] && !prev_q[0]) begin
            count_q <= count_q + 1;
        end
    end
endmodule
`default_nettype wire

// ==== rosr_tb.sv ====
// Self-checking bench for the rear output router.
// Assumes the router answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rosr_pkg::*;
    localparam int N = 7;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic [23:0] src = '0;
    logic [7:0] rdata_out;
    logic [N-1:0] conn_out, conn_oe_out, line;
    int tcount, t0, k;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [5:0] codes [24] = '{6'h04, 6'h05, 6'h06, 6'h0A, 6'h0B, 6'h0D, 6'h14, 6'h15,
        6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1C, 6'h20, 6'h21, 6'h23, 6'h24, 6'h25,
        6'h26, 6'h27, 6'h28, 6'h29, 6'h2A};
    rosr_router #(.NUM_OUT(N)) DUT (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .chip_clk_in(src[0]), .sfn_reset_in(src[1]), .sfn_sync_in(src[2]),
        .sch_slot_in(src[3]), .frame_10ms_in(src[4]), .frame_80ms_in(src[5]),
        .dpdch_clk_in(src[6]), .tpc_clk_in(src[7]), .tfci_clk_in(src[8]),
        .pilot_clk_in(src[9]), .dpch_stream_in(src[10]), .dpch_slot_in(src[11]),
        .dpch_frame_in(src[12]), .dpch_clk_in(src[13]), .cm_frame_ind_in(src[14]),
        .cm_gap_in(src[15]), .pich_data_in(src[16]), .pich_slot_in(src[17]),
        .pich_frame_in(src[18]), .pccpch_clk_in(src[19]), .pccpch_data_in(src[20]),
        .chip_waveform_playback_frame_in(src[21]), .tpc_bits_in(src[22]),
        .multi_unit_sync_trigger_in(src[23]), .conn_out(conn_out), .conn_oe_out(conn_oe_out));
    rosr_far_end #(.NUM_OUT(N)) far (.clk_in(clk_in), .conn_in(conn_out),
        .oe_in(conn_oe_out), .line_out(line), .trig_count_out(tcount));
    // ==========================================================
    // Clock and hang guard
    initial forever #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Select a code, drive sources, return connector level one cycle on
    task automatic route(input int i, input logic [5:0] c, input logic [23:0] s,
        output logic [7:0] v);
        wr(i[3:0], {2'b00, c});
        src <= s;
        @(posedge clk_in);
        #1 v = {7'h00, conn_out[i]};
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        logic [7:0] v;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        #1 check({1'b0, conn_oe_out}, 8'h00);
        check({1'b0, conn_out}, 8'h00);
        for (k = 0; k < N; k++) begin
            rd(k[3:0], v);
            check(v, 8'h00);
        end
        wr(4'hF, 8'h5A);
        rd(4'hF, v);
        check(v, 8'h00);
        route(0, 6'h20, 24'h1 << 14, v);
        check(v, 8'h00);
        route(0, 6'h21, 24'h1 << 15, v);
        check(v, 8'h00);
        wr(4'h8, 8'h01);
        rd(4'h8, v);
        check(v, 8'h01);
        // Each source alone high on rotating connectors, then alone low on connector 0
        for (k = 0; k < 24; k++) begin
            route(k % N, codes[k], 24'h1 << k, v);
            check(v, 8'h01);
            route(0, codes[k], ~(24'h1 << k), v);
            check(v, 8'h00);
        end
        route(0, 6'h14, 24'h8040, v);
        check(v, 8'h01);
        rd(4'h9, v);
        check(v, 8'h01);
        route(0, 6'h1E, 24'h000040, v);
        check(v, 8'h01);
        route(0, 6'h1E, 24'h8040, v);
        check(v, 8'h00);
        wr(4'h8, 8'h00);
        route(0, 6'h1E, 24'h8040, v);
        check(v, 8'h01);
        route(3, 6'h00, 24'hFFFFFF, v);
        check(v, 8'h00);
        check({7'h00, conn_oe_out[3]}, 8'h00);
        wr(4'h0, 8'h04);
        wr(4'h1, 8'h05);
        wr(4'h5, 8'hC3);
        rd(4'h0, v);
        check(v, 8'h04);
        rd(4'h1, v);
        check(v, 8'h05);
        rd(4'h5, v);
        check(v, 8'h03);
        check({7'h00, conn_oe_out[5]}, 8'h01);
        route(0, 6'h2A, 24'h000000, v);
        repeat (2) @(posedge clk_in);
        t0 = tcount;
        check({7'h00, line[0]}, 8'h00);
        src <= 24'h800000;
        @(posedge clk_in);
        src <= 24'h000000;
        repeat (3) @(posedge clk_in);
        check(8'(tcount - t0), 8'h01);
        end_of_test();
    end
endmodule
`default_nettype wire
